//--- src/otc_top.sv
// Transmit control, laser fault latch and two-wire management memory.
// Assumes pins arrive asynchronous and the monitor words come from
// logic on clk_sys_i; the host provides pull-ups on SDA and fault.
//
// Overview of operation
// - Reads at bus address 0xA0 return a 256-byte identification memory.
// - Accesses at bus address 0xA2 reach a 256-byte diagnostic page.
// - Bias, transmit power, supply, temperature and rx power are readable.
// - A high transmit-off pin shuts the transmitter off and low allows it.
// - Cycling the transmit-off pin high then low resets the transmitter.
// - An undriven transmit-off pin counts as high and keeps the laser off.
// - Byte 110 bit 6 is a writable soft off and bit 7 reads the pin.
// - The transmitter is off when the soft bit or the pin is set.
// - A laser fault raises the fault output and turns the laser off.
// - The fault output is open collector, low when normal, high on fault.
// - The fault latches and clears only by a pin toggle or power cycle.
// - The fault state appears at byte 110 bit 2.
// - Transmit-off and loss-of-signal flags are mirrored in the page.
// - The signal-lost output is high on loss of light, also at bit 1.
`timescale 1ns/100ps
module otc_top (
  // Clock and reset.
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  // Host control pin and internal detectors.
  input  wire logic                  tx_off_pin_i,
  input  wire logic                  laser_fault_det_i,
  input  wire logic                  receive_signal_lost_det_i,
  input  wire otc_pkg::otc_monitor_t monitor_i,
  // Two-wire management bus.
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_n_o,
  // Transmitter and status outputs.
  output logic                       laser_disable_o,
  output logic                       tx_fault_o,
  output logic                       tx_fault_oe_n_o,
  output logic                       receive_signal_lost_o
);

  logic [7:0] id_mem   [0:255];
  logic [7:0] diag_mem [0:255];

  // Synchronisers for all pin and detector inputs.
  logic [1:0] scl_s_q, sda_s_q, off_s_q, flt_s_q, los_s_q;
  logic [1:0] scl_s_d, sda_s_d, off_s_d, flt_s_d, los_s_d;
  logic       scl_p_q, sda_p_q, off_p_q;

  // Control state.
  logic soft_off_q, soft_off_d;
  logic fault_q, fault_d;
  logic dis_q, dis_d;
  logic los_q, los_d;
  logic [7:0] stat_q, stat_d;

  // Two-wire slave state.
  otc_pkg::otc_state_t state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] ptr_q, ptr_d;
  logic       page_q, page_d;
  logic       rw_q, rw_d;
  logic       first_q, first_d;
  logic       oe_n_q, oe_n_d;

  logic       scl, sda, off_pin, scl_rise, scl_fall, start, stop;
  logic       off_rise, wr_en, wr_page;
  logic [7:0] wr_addr, wr_data, rdata;

  assign scl      = scl_s_q[1];
  assign sda      = sda_s_q[1];
  assign off_pin  = off_s_q[1];
  assign scl_rise = scl & ~scl_p_q;
  assign scl_fall = ~scl & scl_p_q;
  assign start    = scl & scl_p_q & ~sda & sda_p_q;
  assign stop     = scl & scl_p_q & sda & ~sda_p_q;
  assign off_rise = off_pin & ~off_p_q;

  always_comb begin
    scl_s_d = {scl_s_q[0], scl_i};
    sda_s_d = {sda_s_q[0], sda_i};
    off_s_d = {off_s_q[0], tx_off_pin_i};
    flt_s_d = {flt_s_q[0], laser_fault_det_i};
    los_s_d = {los_s_q[0], receive_signal_lost_det_i};
  end

  // Pin synchronisers start high so the laser stays off until released.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      off_s_q <= {otc_pkg::PIN_OFF_RST, otc_pkg::PIN_OFF_RST};
      flt_s_q <= 2'h0;
      los_s_q <= 2'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      off_p_q <= otc_pkg::PIN_OFF_RST;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      off_s_q <= off_s_d;
      flt_s_q <= flt_s_d;
      los_s_q <= los_s_d;
      scl_p_q <= scl;
      sda_p_q <= sda;
      off_p_q <= off_pin;
    end
  end

  // Read data mux for the selected page.
  always_comb begin
    rdata = id_mem[ptr_q];
    if (page_q) begin
      unique case (ptr_q)
        otc_pkg::TEMP_MSB_OFS:  rdata = monitor_i.temperature[15:8];
        otc_pkg::TEMP_LSB_OFS:  rdata = monitor_i.temperature[7:0];
        otc_pkg::VCC_MSB_OFS:   rdata = monitor_i.supply_voltage[15:8];
        otc_pkg::VCC_LSB_OFS:   rdata = monitor_i.supply_voltage[7:0];
        otc_pkg::BIAS_MSB_OFS:  rdata = monitor_i.laser_bias[15:8];
        otc_pkg::BIAS_LSB_OFS:  rdata = monitor_i.laser_bias[7:0];
        otc_pkg::TXPWR_MSB_OFS: rdata = monitor_i.tx_power[15:8];
        otc_pkg::TXPWR_LSB_OFS: rdata = monitor_i.tx_power[7:0];
        otc_pkg::RXPWR_MSB_OFS: rdata = monitor_i.rx_power[15:8];
        otc_pkg::RXPWR_LSB_OFS: rdata = monitor_i.rx_power[7:0];
        otc_pkg::CTRL_STAT_OFS: rdata = stat_q;
        default:                rdata = diag_mem[ptr_q];
      endcase
    end
  end

  // Two-wire slave sequencing.
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    ptr_d   = ptr_q;
    page_d  = page_q;
    rw_d    = rw_q;
    first_d = first_q;
    oe_n_d  = oe_n_q;
    wr_en   = 1'b0;
    wr_page = page_q;
    wr_addr = ptr_q;
    wr_data = shift_q;
    if (stop) begin
      state_d = otc_pkg::ST_IDLE;
      oe_n_d  = 1'b1;
    end else if (start) begin
      state_d = otc_pkg::ST_ADDR;
      cnt_d   = 4'h0;
      oe_n_d  = 1'b1;
    end else begin
      unique case (state_q)
        otc_pkg::ST_IDLE: begin
          oe_n_d = 1'b1;
        end
        otc_pkg::ST_ADDR, otc_pkg::ST_WR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda};
            cnt_d   = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == otc_pkg::BIT_CNT_FULL) begin
            oe_n_d  = 1'b0;
            state_d = otc_pkg::ST_ACK;
            if (state_q == otc_pkg::ST_ADDR) begin
              rw_d    = shift_q[0];
              page_d  = (shift_q[7:1] == otc_pkg::DIAG_DEV_ADDR);
              first_d = 1'b1;
              if (shift_q[7:1] != otc_pkg::ID_DEV_ADDR &&
                  shift_q[7:1] != otc_pkg::DIAG_DEV_ADDR) begin
                oe_n_d  = 1'b1;
                state_d = otc_pkg::ST_IDLE;
              end
            end else if (first_q) begin
              ptr_d   = shift_q;
              first_d = 1'b0;
            end else begin
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        otc_pkg::ST_RD: begin
          if (scl_fall) begin
            if (cnt_q == otc_pkg::BIT_CNT_FULL) begin
              oe_n_d  = 1'b1;
              state_d = otc_pkg::ST_RACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_n_d  = shift_q[6];
              cnt_d   = cnt_q + 4'h1;
            end
          end
        end
        otc_pkg::ST_ACK, otc_pkg::ST_RACK: begin
          if (scl_rise && state_q == otc_pkg::ST_RACK && sda) begin
            state_d = otc_pkg::ST_IDLE;
          end else if (scl_fall) begin
            cnt_d  = 4'h0;
            oe_n_d = 1'b1;
            if (rw_q) begin
              shift_d = rdata;
              oe_n_d  = rdata[7];
              cnt_d   = 4'h1;
              ptr_d   = ptr_q + 8'h01;
              state_d = otc_pkg::ST_RD;
            end else begin
              state_d = otc_pkg::ST_WR;
            end
          end
        end
        default: state_d = otc_pkg::ST_IDLE;
      endcase
    end
  end

  // Transmit control and fault latch.
  always_comb begin
    soft_off_d = soft_off_q;
    if (wr_en && wr_page && wr_addr == otc_pkg::CTRL_STAT_OFS) begin
      soft_off_d = wr_data[otc_pkg::SOFT_OFF_BIT];
    end
    // fault latch, pin toggle clears, new fault wins.
    fault_d = flt_s_q[1] | (fault_q & ~off_rise);
    dis_d = off_pin | soft_off_d | fault_d;
    los_d = los_s_q[1];
    stat_d = 8'h00;
    stat_d[otc_pkg::PIN_OFF_BIT]  = off_pin;
    stat_d[otc_pkg::SOFT_OFF_BIT] = soft_off_q;
    stat_d[otc_pkg::FAULT_BIT]    = fault_q;
    stat_d[otc_pkg::LOS_BIT]      = los_s_q[1];
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q    <= otc_pkg::ST_IDLE;
      shift_q    <= 8'h00;
      cnt_q      <= 4'h0;
      ptr_q      <= 8'h00;
      page_q     <= 1'b0;
      rw_q       <= 1'b0;
      first_q    <= 1'b0;
      oe_n_q     <= 1'b1;
      soft_off_q <= otc_pkg::SOFT_OFF_RST;
      fault_q    <= 1'b0;
      dis_q      <= 1'b1;
      los_q      <= 1'b0;
      stat_q     <= 8'h00;
    end else begin
      state_q    <= state_d;
      shift_q    <= shift_d;
      cnt_q      <= cnt_d;
      ptr_q      <= ptr_d;
      page_q     <= page_d;
      rw_q       <= rw_d;
      first_q    <= first_d;
      oe_n_q     <= oe_n_d;
      soft_off_q <= soft_off_d;
      fault_q    <= fault_d;
      dis_q      <= dis_d;
      los_q      <= los_d;
      stat_q     <= stat_d;
    end
  end

  // Memory arrays hold no reset; the identification page is loaded by writes.
  always_ff @(posedge clk_sys_i) begin
    if (wr_en && !wr_page) begin
      id_mem[wr_addr] <= wr_data;
    end
    if (wr_en && wr_page) begin
      diag_mem[wr_addr] <= wr_data;
    end
  end

  // open collector fault, pulled low while no fault is latched.
  assign tx_fault_o            = 1'b0;
  assign tx_fault_oe_n_o       = fault_q;
  assign sda_o                 = 1'b0;
  assign sda_oe_n_o            = oe_n_q;
  assign laser_disable_o       = dis_q;
  assign receive_signal_lost_o = los_q;

endmodule

//--- src/otc_pkg.sv
// Package for the optical module transmit control and management logic.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package otc_pkg;

  // Two-wire device addresses (7-bit form of the 8-bit bus addresses).
  localparam logic [6:0] ID_DEV_ADDR   = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;

  // Diagnostic page offsets.
  localparam logic [7:0] TEMP_MSB_OFS  = 8'h60;
  localparam logic [7:0] TEMP_LSB_OFS  = 8'h61;
  localparam logic [7:0] VCC_MSB_OFS   = 8'h62;
  localparam logic [7:0] VCC_LSB_OFS   = 8'h63;
  localparam logic [7:0] BIAS_MSB_OFS  = 8'h64;
  localparam logic [7:0] BIAS_LSB_OFS  = 8'h65;
  localparam logic [7:0] TXPWR_MSB_OFS = 8'h66;
  localparam logic [7:0] TXPWR_LSB_OFS = 8'h67;
  localparam logic [7:0] RXPWR_MSB_OFS = 8'h68;
  localparam logic [7:0] RXPWR_LSB_OFS = 8'h69;
  localparam logic [7:0] CTRL_STAT_OFS = 8'h6E;

  // Field positions inside the control and status byte.
  localparam int PIN_OFF_BIT  = 7;
  localparam int SOFT_OFF_BIT = 6;
  localparam int FAULT_BIT    = 2;
  localparam int LOS_BIT      = 1;

  // Reset values and the bit count that completes a byte.
  localparam logic       SOFT_OFF_RST = 1'b0;
  localparam logic       PIN_OFF_RST  = 1'b1;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;

  // Real-time monitor values, each a 16-bit word sent MSB first.
  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] supply_voltage;
    logic [15:0] laser_bias;
    logic [15:0] tx_power;
    logic [15:0] rx_power;
  } otc_monitor_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK  = 3'h2,
    ST_WR   = 3'h3,
    ST_RD   = 3'h4,
    ST_RACK = 3'h5
  } otc_state_t;

endpackage

//--- bench/otc_top_asserts.sv
// Checker for the transmit control and management pins.
// Assumes it is bound to otc_top and sees only its ports.
`timescale 1ns/100ps
module otc_top_asserts (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Watched pins.
  input wire logic tx_off_pin_i,
  input wire logic laser_fault_det_i,
  input wire logic receive_signal_lost_det_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic laser_disable_o,
  input wire logic tx_fault_o,
  input wire logic tx_fault_oe_n_o,
  input wire logic receive_signal_lost_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_pin_lo;
    (!tx_off_pin_i && !laser_fault_det_i)[*6];
  endsequence
  sequence s_pin_hi;
    (tx_off_pin_i && !laser_fault_det_i)[*6];
  endsequence
  property p_los_hi;
    receive_signal_lost_det_i[*5] |-> receive_signal_lost_o;
  endproperty
  property p_los_lo;
    (!receive_signal_lost_det_i)[*5] |-> !receive_signal_lost_o;
  endproperty
  property p_pin_off;
    tx_off_pin_i[*5] |-> laser_disable_o;
  endproperty
  property p_flt_set;
    laser_fault_det_i[*6] |-> tx_fault_oe_n_o && laser_disable_o;
  endproperty
  property p_flt_hold;
    (!tx_off_pin_i)[*4] ##0 tx_fault_oe_n_o |=> tx_fault_oe_n_o;
  endproperty
  property p_flt_clr;
    s_pin_lo ##1 s_pin_hi |-> !tx_fault_oe_n_o && laser_disable_o;
  endproperty
  property p_od;
    !tx_fault_o && !sda_o;
  endproperty
  property p_drv;
    $fell(sda_oe_n_o) |-> !scl_i;
  endproperty
  a_los_hi: assert property (p_los_hi) else $error("los high");
  a_los_lo: assert property (p_los_lo) else $error("los low");
  a_pin_off: assert property (p_pin_off) else $error("pin");
  a_flt_set: assert property (p_flt_set) else $error("set");
  a_flt_hold: assert property (p_flt_hold) else $error("hold");
  a_flt_clr: assert property (p_flt_clr) else $error("clear");
  a_od: assert property (p_od) else $error("open drain");
  a_drv: assert property (p_drv) else $error("sda");
endmodule
bind otc_top otc_top_asserts CHK (
  .clk_sys_i, .reset_i, .tx_off_pin_i, .laser_fault_det_i,
  .receive_signal_lost_det_i, .scl_i, .sda_o, .sda_oe_n_o,
  .laser_disable_o, .tx_fault_o, .tx_fault_oe_n_o, .receive_signal_lost_o
);

//--- bench/otc_host_model.sv
// Host board model: two-wire master on an open-drain data line.
// Assumes the device pulls SDA only through its active-low enable.
`timescale 1ns/100ps
module otc_host_model (
  // Clock.
  input  wire logic clk_sys_i,
  // Device side of the data line.
  input  wire logic dev_sda_i,
  input  wire logic dev_sda_oe_n_i,
  // Resolved bus lines.
  output logic      scl_o,
  output logic      sda_o
);
  logic rel = 1'b1;
  // A released line floats high on the board pull-up.
  assign sda_o = rel & (dev_sda_oe_n_i | dev_sda_i);
  initial scl_o = 1'b1;
  // Each phase spans eight system clocks, above the minimum hold.
  task automatic ph;
    repeat (8) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic start;
    rel = 1'b1;
    ph;
    scl_o = 1'b1;
    ph;
    rel = 1'b0;
    ph;
    scl_o = 1'b0;
    ph;
  endtask
  task automatic stop;
    rel = 1'b0;
    ph;
    scl_o = 1'b1;
    ph;
    rel = 1'b1;
    ph;
  endtask
  task automatic tbit(input logic b, output logic r);
    rel = b;
    ph;
    scl_o = 1'b1;
    ph;
    r = sda_o;
    scl_o = 1'b0;
    ph;
  endtask
  task automatic xfer(input logic [7:0] w, input logic m,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) tbit(w[i], r[i]);
    tbit(m, a);
  endtask
endmodule

//--- bench/tb.sv
// Self-checking bench of the transmit control and management block.
// Assumes the host model is the only bus master; pins have pull-ups.
`timescale 1ns/100ps
module tb;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic pin = 1'b1;
  logic flt = 1'b0;
  logic los = 1'b0;
  otc_pkg::otc_monitor_t mon = 80'h1234_5678_9ABC_DEF0_0F1E;
  logic scl, sda, dev_sda, sda_oe_n, las_off, flt_d, flt_oe_n, los_o, ack;
  logic [7:0] rx;
  wire flt_pin = flt_oe_n | flt_d;
  int bad_count = 0;
  int check_count = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  otc_top DUT (
    .clk_sys_i, .reset_i, .tx_off_pin_i(pin), .laser_fault_det_i(flt),
    .receive_signal_lost_det_i(los), .monitor_i(mon), .scl_i(scl),
    .sda_i(sda), .sda_o(dev_sda), .sda_oe_n_o(sda_oe_n),
    .laser_disable_o(las_off), .tx_fault_o(flt_d),
    .tx_fault_oe_n_o(flt_oe_n), .receive_signal_lost_o(los_o));
  otc_host_model HOST (.clk_sys_i, .dev_sda_i(dev_sda),
    .dev_sda_oe_n_i(sda_oe_n), .scl_o(scl), .sda_o(sda));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic addr(input logic [7:0] d, input logic [7:0] o);
    HOST.start;
    HOST.xfer(d, 1'b1, rx, ack);
    chk(8'(ack), 8'h00);
    HOST.xfer(o, 1'b1, rx, ack);
  endtask
  task automatic wr(input logic [7:0] d, input logic [7:0] o,
                    input logic [7:0] v);
    addr(d, o);
    HOST.xfer(v, 1'b1, rx, ack);
    HOST.stop;
  endtask
  task automatic rd(input logic [7:0] d, input logic [7:0] o,
                    input logic [79:0] e, input int n);
    addr(d, o);
    HOST.start;
    HOST.xfer(d | 8'h01, 1'b1, rx, ack);
    for (int i = 0; i < n; i++) begin
      HOST.xfer(8'hFF, 1'(i == n - 1), rx, ack);
      chk(rx, e[8*(n-1-i) +: 8]);
    end
    HOST.stop;
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    HOST.ph;
    chk(8'(las_off), 8'h01);
    rd(8'hA2, 8'h6E, 80'h80, 1);
    pin = 1'b0;
    HOST.ph;
    chk(8'(las_off), 8'h00);
    rd(8'hA2, 8'h6E, 80'h00, 1);
    wr(8'hA2, 8'h6E, 8'hFF);
    rd(8'hA2, 8'h6E, 80'h40, 1);
    chk(8'(las_off), 8'h01);
    wr(8'hA2, 8'h6E, 8'h00);
    chk(8'(las_off), 8'h00);
    los = 1'b1;
    HOST.ph;
    chk(8'(los_o), 8'h01);
    rd(8'hA2, 8'h6E, 80'h02, 1);
    los = 1'b0;
    flt = 1'b1;
    HOST.ph;
    flt = 1'b0;
    HOST.ph;
    chk(8'(flt_pin), 8'h01);
    chk(8'(las_off), 8'h01);
    rd(8'hA2, 8'h6E, 80'h04, 1);
    pin = 1'b1;
    HOST.ph;
    pin = 1'b0;
    HOST.ph;
    chk(8'(flt_pin), 8'h00);
    chk(8'(las_off), 8'h00);
    rd(8'hA2, 8'h60, mon, 10);
    wr(8'hA0, 8'h10, 8'h5A);
    rd(8'hA0, 8'h10, 80'h5A, 1);
    HOST.start;
    HOST.xfer(8'hA4, 1'b1, rx, ack);
    chk(8'(ack), 8'h01);
    HOST.stop;
    // A mid-run reset stands for a power cycle: latch and soft bit clear.
    wr(8'hA2, 8'h6E, 8'h40);
    flt = 1'b1;
    HOST.ph;
    flt = 1'b0;
    chk(8'(flt_pin), 8'h01);
    chk(8'(las_off), 8'h01);
    reset_i = 1'b1;
    HOST.ph;
    reset_i = 1'b0;
    HOST.ph;
    chk(8'(flt_pin), 8'h00);
    chk(8'(las_off), 8'h00);
    rd(8'hA2, 8'h6E, 80'h00, 1);
    print_verdict;
  end
endmodule
